// *** hw/psu_seq_pkg.sv ***
// Package: constants and types for the secondary-side mode sequencer.
// Assumes a 100 MHz core clock and a synchronous active-high reset.
package psu_seq_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned ClkPeriodPs = 10000;   // Core clock period, ps
  localparam int unsigned ProtDelayNs = 18000;   // Protection delay, ns
  // Protection qualify count, longest time rounds down
  localparam int unsigned ProtDelayCyc = (ProtDelayNs * 1000) / ClkPeriodPs;
  localparam int unsigned SoftStartMs = 15;      // Soft start period, ms
  // Soft start count; cycles per ms first, so the product stays in 32 bits
  localparam int unsigned SoftStartCyc =
    SoftStartMs * (1000000000 / ClkPeriodPs);
  localparam int unsigned EnDelayCycDef = 100000; // Default enable delay

  // ****************************************************************
  // Widths and reset values
  // ****************************************************************
  localparam int unsigned RampW = 8;             // Ramp level width
  localparam logic [7:0]  RampMax = 8'h00_FF;    // Full output level
  localparam logic [7:0]  RampZero = 8'h00_00;   // Output off level
  localparam int unsigned CntW = 24;             // Counter width

  // Mode of the sequencer
  typedef enum logic [1:0] {
    MODE_STARTUP,
    MODE_STANDBY,
    MODE_NORMAL,
    MODE_RESTART
  } mode_t;

endpackage

// *** hw/ramp_if.sv ***
// Interface: soft-start ramp control and level between sequencer parts.
// Assumes one clock domain shared by all users.
`timescale 1ns/1ps
interface ramp_if;
  logic             run;    // Ramp toward full when high
  logic             clear;  // Force level to zero
  logic [7:0]       level;  // Present ramp level
  logic             done;   // Level at full

  modport ctrl (output run, output clear, input level, input done);
  modport ramp (input run, input clear, output level, output done);
endinterface

// *** hw/soft_start_ramp.sv ***
// Soft-start ramp: steps a level from zero to full over the soft start.
// Assumes the step enable comes from a divider on the same clock.
`timescale 1ns/1ps
module soft_start_ramp
  import psu_seq_pkg::*;
(
  input  wire logic core_clk,   // Core clock
  input  wire logic sys_rst,    // Synchronous reset
  ramp_if.ramp      rp          // Ramp control
);
  // ****************************************************************
  // Step divider and level
  // ****************************************************************
  localparam logic [CntW-1:0] StepCyc = CntW'(SoftStartCyc / 255);
  logic [CntW-1:0] div_q, div_d;    // Step divider
  logic [7:0]      lvl_q, lvl_d;    // Ramp level

  // Next divider and level
  always_comb begin
    div_d = div_q;
    lvl_d = lvl_q;
    if (rp.clear || !rp.run) begin
      div_d = '0;
      if (rp.clear) lvl_d = RampZero;
    end else if (div_q >= StepCyc - 1'b1) begin
      div_d = '0;
      if (lvl_q != RampMax) lvl_d = lvl_q + 8'h01;
    end else begin
      div_d = div_q + 1'b1;
    end
  end

  // Register state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      div_q <= '0;
      lvl_q <= RampZero;
    end else begin
      div_q <= div_d;
      lvl_q <= lvl_d;
    end
  end

  assign rp.level = lvl_q;
  assign rp.done  = (lvl_q == RampMax);
endmodule

// *** hw/fault_qualifier.sv ***
// Fault qualifier: a fault must persist for the protection delay to act.
// Assumes the raw fault is already synchronised.
`timescale 1ns/1ps
module fault_qualifier
  import psu_seq_pkg::*;
(
  input  wire logic core_clk,   // Core clock
  input  wire logic sys_rst,    // Synchronous reset
  input  wire logic faultRaw,   // Synchronised raw fault
  output logic      faultQual   // Qualified fault level
);
  logic [CntW-1:0] cnt_q, cnt_d;   // Persistence counter
  logic            hit_q, hit_d;   // Qualified flag

  // Count while fault stays present
  always_comb begin
    cnt_d = cnt_q;
    hit_d = 1'b0;
    if (!faultRaw) begin
      cnt_d = '0;
    end else if (cnt_q >= CntW'(ProtDelayCyc - 1)) begin
      hit_d = 1'b1;
    end else begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  // Register counter
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      cnt_q <= '0;
      hit_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      hit_q <= hit_d;
    end
  end

  assign faultQual = hit_q;
endmodule

// *** hw/psu_secondary_mode_sequencer.sv ***
// Top: mode sequencer of a secondary-side power supply controller.
// Assumes all pin inputs are asynchronous and resynchronised here.
//
// Summary of operation
// - Supply below stop: start-up, switches off
// - Supply above start: standby, soft-start standby
// - Off request low: normal, main outputs on
// - Failure or request high: back to standby
// - Overload: protection, mains off, standby on
// - Severe fault: restart, primary shutdown signalled
// - Standby: reduced duty and frequency commanded
// - Programmable delay before main outputs on
// - Low input voltage keeps standby mode
// - Mains soft-start together over 15 ms
// - 12V and 5V never below 3.3V
// - Enable line high only in normal
// - Protect faults qualified by 18 us delay
// - After protection, need request toggle
`timescale 1ns/1ps
module psu_secondary_mode_sequencer
  import psu_seq_pkg::*;
#(
  parameter int unsigned EnDelayCyc = EnDelayCycDef  // Enable delay
) (
  input  wire logic       core_clk,           // Core clock
  input  wire logic       sys_rst,            // Supply under-voltage rst
  input  wire logic       supplyBelowStop,    // Supply below stop level
  input  wire logic       supplyAboveStart,   // Supply above start level
  input  wire logic       supply_off_request_n, // Off request, low=on
  input  wire logic       inputVoltageOk,     // Input above minimum
  input  wire logic       overvoltageProtect, // Raw overvoltage
  input  wire logic       overcurrentProtect, // Raw overcurrent
  input  wire logic       severeFault,        // Shorted switch etc.
  input  wire logic       standbyUnder,       // Standby under-voltage
  output psu_seq_pkg::mode_t mode,            // Present mode
  output logic            switchesOff,        // Force all switches off
  output logic            mainEnable,         // Shared enable line
  output logic            primaryShutdown,    // Shutdown to primary
  output logic            reducedDuty,        // Low duty and frequency
  output logic [7:0]      standbyLevel,       // Standby ramp level
  output logic [7:0]      level12,            // 12 V ramp level
  output logic [7:0]      level5,             // 5 V ramp level
  output logic [7:0]      level3v3            // 3.3 V ramp level
);
  import psu_seq_pkg::*;

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  localparam int unsigned NIn = 8;
  logic [NIn-1:0] syncA_q, syncB_q;   // Two-stage synchroniser
  logic [NIn-1:0] rawIn;              // Raw pin bundle
  assign rawIn = {supplyBelowStop, supplyAboveStart, supply_off_request_n,
                  inputVoltageOk, overvoltageProtect, overcurrentProtect,
                  severeFault, standbyUnder};

  // Two flip-flops before any logic
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      // Off request idles high, every other pin idles low
      syncA_q <= 8'h20;
      syncB_q <= 8'h20;
    end else begin
      syncA_q <= rawIn;
      syncB_q <= syncA_q;
    end
  end

  logic belowStop, aboveStart, offReqN, vinOk, ovRaw, ocRaw, severe, sbUv;
  assign {belowStop, aboveStart, offReqN, vinOk, ovRaw, ocRaw, severe,
          sbUv} = syncB_q;

  // ****************************************************************
  // Protection qualification
  // ****************************************************************
  logic ovQual;   // Qualified overvoltage
  logic ocQual;   // Qualified overcurrent
  fault_qualifier u_ovq (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .faultRaw  (ovRaw),
    .faultQual (ovQual)
  );
  fault_qualifier u_ocq (
    .core_clk  (core_clk),
    .sys_rst   (sys_rst),
    .faultRaw  (ocRaw),
    .faultQual (ocQual)
  );

  // ****************************************************************
  // Soft-start ramps
  // ****************************************************************
  ramp_if sbRamp ();    // Standby output ramp
  ramp_if mnRamp ();    // Shared main output ramp
  soft_start_ramp u_sbr (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .rp       (sbRamp)
  );
  soft_start_ramp u_mnr (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .rp       (mnRamp)
  );

  // ****************************************************************
  // Mode state machine
  // ****************************************************************
  mode_t           mode_q, mode_d;     // Mode register
  logic            latch_q, latch_d;   // Protection latched
  logic            prevOff_q;          // Previous off request
  logic [CntW-1:0] dly_q, dly_d;       // Enable delay counter
  logic            dlyDone;            // Enable delay elapsed
  logic            protFault;          // Main output fault
  logic            reqOn;              // Normal mode requested
  logic            toggle;             // Request went high

  assign protFault = ovQual | ocQual;
  assign reqOn     = !offReqN;
  assign toggle    = offReqN && !prevOff_q;
  assign dlyDone   = (dly_q >= CntW'(EnDelayCyc));

  // Next mode
  always_comb begin
    mode_d  = mode_q;
    latch_d = latch_q;
    // Latch clears once the request is toggled off; set wins
    if (toggle) latch_d = 1'b0;
    if (protFault) latch_d = 1'b1;
    case (mode_q)
      MODE_STARTUP: begin
        if (aboveStart && !belowStop) mode_d = MODE_STANDBY;
      end
      MODE_STANDBY: begin
        // Stay in standby on low input or latched protection
        if (severe) mode_d = MODE_RESTART;
        else if (reqOn && vinOk && !latch_d && !sbUv &&
                 !protFault)
          mode_d = MODE_NORMAL;
      end
      MODE_NORMAL: begin
        if (severe) mode_d = MODE_RESTART;
        else if (!reqOn || protFault || sbUv)
          mode_d = MODE_STANDBY;
      end
      MODE_RESTART: begin
        mode_d = MODE_RESTART;   // Left only via supply collapse
      end
      default: mode_d = MODE_STARTUP;
    endcase
    if (belowStop) mode_d = MODE_STARTUP;
  end

  // Enable delay counter, counts in normal mode
  always_comb begin
    dly_d = '0;
    if (mode_q == MODE_NORMAL)
      dly_d = dlyDone ? dly_q : dly_q + 1'b1;
  end

  // Register mode state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      mode_q    <= MODE_STARTUP;
      latch_q   <= 1'b0;
      prevOff_q <= 1'b1;
      dly_q     <= '0;
    end else begin
      mode_q    <= mode_d;
      latch_q   <= latch_d;
      prevOff_q <= offReqN;
      dly_q     <= dly_d;
    end
  end

  // ****************************************************************
  // Ramp control
  // ****************************************************************
  logic mainGo;   // Main outputs may ramp
  assign mainGo = (mode_q == MODE_NORMAL) && dlyDone;

  always_comb begin
    sbRamp.run   = (mode_q == MODE_STANDBY) ||
                   (mode_q == MODE_NORMAL);
    sbRamp.clear = (mode_q == MODE_STARTUP) ||
                   (mode_q == MODE_RESTART);
    mnRamp.run   = mainGo;
    mnRamp.clear = !mainGo;
  end

  // ****************************************************************
  // Output registers
  // ****************************************************************
  logic       swOff_q, en_q, shut_q, red_q;   // Control outputs
  logic [7:0] sb_q, l12_q, l5_q, l33_q;       // Ramp levels
  mode_t      modeOut_q;                      // Mode copy

  // One shared ramp; 3.3 V is held one step lower so others lead it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      modeOut_q <= MODE_STARTUP;
      swOff_q   <= 1'b1;
      en_q      <= 1'b0;
      shut_q    <= 1'b0;
      red_q     <= 1'b0;
      sb_q      <= RampZero;
      l12_q     <= RampZero;
      l5_q      <= RampZero;
      l33_q     <= RampZero;
    end else begin
      modeOut_q <= mode_q;
      swOff_q   <= (mode_q == MODE_STARTUP);
      en_q      <= mainGo;
      shut_q    <= (mode_q == MODE_RESTART);
      red_q     <= (mode_q == MODE_STANDBY);
      sb_q      <= sbRamp.level;
      l12_q     <= mnRamp.level;
      l5_q      <= mnRamp.level;
      l33_q     <= (mnRamp.level == RampZero) ? RampZero :
                   mnRamp.level - 8'h01;
    end
  end

  assign mode            = modeOut_q;
  assign switchesOff     = swOff_q;
  assign mainEnable      = en_q;
  assign primaryShutdown = shut_q;
  assign reducedDuty     = red_q;
  assign standbyLevel    = sb_q;
  assign level12         = l12_q;
  assign level5          = l5_q;
  assign level3v3        = l33_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_fault_then_mode;
    (mode_q == MODE_NORMAL) && protFault && !severe && !belowStop;
  endsequence

  property p_stop_startup;
    @(posedge core_clk) disable iff (sys_rst)
      belowStop |=> mode_q == MODE_STARTUP ##1 switchesOff;
  endproperty
  a_stop_startup: assert property (p_stop_startup)
    else $error("Supply below stop did not force start-up");

  property p_start_standby;
    @(posedge core_clk) disable iff (sys_rst)
      (mode_q == MODE_STARTUP) && aboveStart && !belowStop
        |=> mode_q == MODE_STANDBY;
  endproperty
  a_start_standby: assert property (p_start_standby)
    else $error("Start threshold did not enter standby");

  property p_prot_standby;
    @(posedge core_clk) disable iff (sys_rst)
      s_fault_then_mode |=> mode_q == MODE_STANDBY ##2 !mainEnable;
  endproperty
  a_prot_standby: assert property (p_prot_standby)
    else $error("Protection did not drop main outputs");

  property p_restart;
    @(posedge core_clk) disable iff (sys_rst)
      (mode_q == MODE_RESTART) |=> primaryShutdown;
  endproperty
  a_restart: assert property (p_restart)
    else $error("Restart did not signal primary shutdown");

  property p_enable_normal;
    @(posedge core_clk) disable iff (sys_rst)
      mainEnable |-> $past(mode_q) == MODE_NORMAL;
  endproperty
  a_enable_normal: assert property (p_enable_normal)
    else $error("Enable line high outside normal mode");

  property p_seq_order;
    @(posedge core_clk) disable iff (sys_rst)
      (level12 >= level3v3) && (level5 >= level3v3);
  endproperty
  a_seq_order: assert property (p_seq_order)
    else $error("3.3 V output above 12 V or 5 V");

  property p_low_vin;
    @(posedge core_clk) disable iff (sys_rst)
      (mode_q == MODE_STANDBY) && !vinOk && !belowStop
        |=> mode_q != MODE_NORMAL;
  endproperty
  a_low_vin: assert property (p_low_vin)
    else $error("Normal entered with low input voltage");

  property p_reduced;
    @(posedge core_clk) disable iff (sys_rst)
      (mode_q == MODE_STANDBY) |=> reducedDuty;
  endproperty
  a_reduced: assert property (p_reduced)
    else $error("Standby without reduced duty command");

  property p_delay;
    @(posedge core_clk) disable iff (sys_rst)
      $rose(mode_q == MODE_NORMAL) |-> !mainGo [*4];
  endproperty
  a_delay: assert property (p_delay)
    else $error("Main outputs enabled without delay");
endmodule

// *** dv/companion_model.sv ***
// Model of the companion secondary controller beside the sequencer.
// Assumes it sees the shared enable line on the sequencer's clock.
`timescale 1ns/1ps
module companion_model (
  input  wire logic core_clk,    // Core clock
  input  wire logic sys_rst,     // Synchronous reset
  input  wire logic mainEnable,  // Shared enable line
  output logic      companionOn  // Companion 3.3 V and 5 V running
);
  // ****************************************************************
  // Output switching
  // ****************************************************************
  logic onD;  // Next companion state

  // Outputs follow the enable line
  always_comb begin
    onD = mainEnable;
  end

  // Register the companion state
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      companionOn <= 1'h0;
    end else begin
      companionOn <= onD;
    end
  end
endmodule

// *** dv/testbench.sv ***
// Testbench: walks the mode sequencer through its modes and faults.
// Assumes the design package and a companion model are compiled first.
`timescale 1ns/1ps
module testbench;
  import psu_seq_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam int unsigned EnDly = 10;  // Short enable delay
  logic       core_clk = 1'h0;         // Core clock
  logic       sys_rst = 1'h1;          // Reset
  logic       belowStop = 1'h0;        // Supply below stop
  logic       aboveStart = 1'h0;       // Supply above start
  logic       offReqN = 1'h1;          // Off request, low=on
  logic       vinOk = 1'h0;            // Input voltage ok
  logic       overvoltage_protect = 1'h0;              // Raw overvoltage
  logic       overcurrent_protect = 1'h0;              // Raw overcurrent
  logic       severe = 1'h0;           // Severe fault
  logic       sbUnder = 1'h0;          // Standby under-voltage
  mode_t      mode;                    // Present mode
  logic       swOff;                   // Switches off
  logic       mainEnable;              // Shared enable line
  logic       primShut;                // Primary shutdown
  logic       redDuty;                 // Reduced duty
  logic [7:0] sbLvl;                   // Standby level
  logic [7:0] l12;                     // 12 V level
  logic [7:0] l5;                      // 5 V level
  logic [7:0] l33;                     // 3.3 V level
  logic       compOn;                  // Companion running
  int         error_cnt = 0;           // Mismatches
  int         check_count = 0;         // Comparisons
  int         cycles = 0;              // Cycle counter

  // Clock of 10 ns
  always #5 core_clk = ~core_clk;

  psu_secondary_mode_sequencer #(.EnDelayCyc(EnDly)) dut (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .supplyBelowStop(belowStop), .supplyAboveStart(aboveStart),
    .supply_off_request_n(offReqN), .inputVoltageOk(vinOk),
    .overvoltageProtect(overvoltage_protect), .overcurrentProtect(overcurrent_protect),
    .severeFault(severe), .standbyUnder(sbUnder), .mode(mode),
    .switchesOff(swOff), .mainEnable(mainEnable),
    .primaryShutdown(primShut), .reducedDuty(redDuty),
    .standbyLevel(sbLvl), .level12(l12), .level5(l5), .level3v3(l33));

  companion_model partner (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .mainEnable(mainEnable), .companionOn(compOn));

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Compare one value
  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Wait at falling edges for a mode, bounded
  task automatic wait_mode(input mode_t m, input int lim);
    int i;
    i = 0;
    while (mode !== m && i < lim) begin
      @(negedge core_clk);
      i++;
    end
    chk("mode", 8'(m), 8'(mode));
  endtask

  // Idle some cycles
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // Verdict and stop
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values
  task automatic t_reset;
    chk("mode", 8'(MODE_STARTUP), 8'(mode));
    chk("switchesOff", 8'h01, 8'(swOff));
    chk("mainEnable", 8'h00, 8'(mainEnable));
    $display("test reset done");
  endtask

  // Start-up to standby with soft start
  task automatic t_standby;
    aboveStart = 1'h1;
    wait_mode(MODE_STANDBY, 40);
    idle(2);
    chk("switchesOff", 8'h00, 8'(swOff));
    chk("reducedDuty", 8'h01, 8'(redDuty));
    chk("mainEnable", 8'h00, 8'(mainEnable));
    idle(7000);
    chk("standbyRising", 8'h01, 8'(sbLvl != 8'h00));
    chk("mainLevel", 8'h00, l12);
    $display("test standby done");
  endtask

  // Low input voltage blocks normal, then normal with delay and ramp
  task automatic t_normal;
    int i;
    offReqN = 1'h0;
    idle(40);
    chk("mode", 8'(MODE_STANDBY), 8'(mode));
    vinOk = 1'h1;
    wait_mode(MODE_NORMAL, 40);
    chk("mainEnable", 8'h00, 8'(mainEnable));
    i = 0;
    while (mainEnable !== 1'h1 && i < EnDly + 10) begin
      @(negedge core_clk);
      i++;
    end
    chk("mainEnable", 8'h01, 8'(mainEnable));
    chk("delayLong", 8'h01, 8'(i == EnDly));
    idle(2);
    chk("companionOn", 8'h01, 8'(compOn));
    chk("reducedDuty", 8'h00, 8'(redDuty));
    idle(7000);
    chk("level12Rising", 8'h01, 8'(l12 != 8'h00));
    chk("level5", l12, l5);
    chk("order33", 8'h01, 8'(l33 <= l5 && l33 <= l12));
    $display("test normal done");
  endtask

  // Short fault ignored, long fault latches protection
  task automatic t_protect;
    overvoltage_protect = 1'h1;
    idle(1000);
    overvoltage_protect = 1'h0;
    idle(20);
    chk("mode", 8'(MODE_NORMAL), 8'(mode));
    overcurrent_protect = 1'h1;
    idle(1700);
    chk("mode", 8'(MODE_NORMAL), 8'(mode));
    wait_mode(MODE_STANDBY, 200);
    idle(2);
    chk("mainEnable", 8'h00, 8'(mainEnable));
    chk("standbyOn", 8'h01, 8'(sbLvl != 8'h00));
    overcurrent_protect = 1'h0;
    idle(40);
    chk("mode", 8'(MODE_STANDBY), 8'(mode));
    offReqN = 1'h1;
    idle(20);
    offReqN = 1'h0;
    wait_mode(MODE_NORMAL, 40);
    $display("test protect done");
  endtask

  // Standby under-voltage and request high both return to standby
  task automatic t_leave;
    sbUnder = 1'h1;
    wait_mode(MODE_STANDBY, 40);
    sbUnder = 1'h0;
    wait_mode(MODE_NORMAL, 40);
    offReqN = 1'h1;
    wait_mode(MODE_STANDBY, 40);
    idle(2);
    chk("mainEnable", 8'h00, 8'(mainEnable));
    $display("test leave done");
  endtask

  // Severe fault then supply loss
  task automatic t_restart;
    severe = 1'h1;
    wait_mode(MODE_RESTART, 40);
    idle(2);
    chk("primaryShutdown", 8'h01, 8'(primShut));
    severe = 1'h0;
    idle(40);
    chk("mode", 8'(MODE_RESTART), 8'(mode));
    belowStop = 1'h1;
    aboveStart = 1'h0;
    wait_mode(MODE_STARTUP, 40);
    idle(2);
    chk("switchesOff", 8'h01, 8'(swOff));
    chk("primaryShutdown", 8'h00, 8'(primShut));
    $display("test restart done");
  endtask

  // Main sequence
  initial begin
    repeat (5) @(negedge core_clk);
    sys_rst = 1'h0;
    idle(1);
    t_reset();
    t_standby();
    t_normal();
    t_protect();
    t_leave();
    t_restart();
    end_of_test();
  end
endmodule
